// File: src/gcs_defines.svh
`ifndef GCS_DEFINES_SVH
`define GCS_DEFINES_SVH

`define GCS_CLK_MHZ 100
`define GCS_US_TO_CYC(us) ((us) * `GCS_CLK_MHZ)

`define GCS_OFF_CMD 7'h00
`define GCS_OFF_FLAGS1 7'h01
`define GCS_OFF_TEMP 7'h02
`define GCS_OFF_AVAIL_CHARGE_HIGH 7'h03
`define GCS_OFF_PACKID 7'h04
`define GCS_OFF_LMD 7'h05
`define GCS_OFF_FLAGS2 7'h06
`define GCS_OFF_PPD 7'h07
`define GCS_OFF_PPU 7'h08
`define GCS_OFF_CPI 7'h09
`define GCS_OFF_VBAT 7'h0B
`define GCS_OFF_VTS 7'h0C
`define GCS_OFF_COMP_CAPACITY_HIGH 7'h0D
`define GCS_OFF_COMP_CAPACITY_LOW 7'h0E
`define GCS_OFF_SCALED_ENERGY_HIGH 7'h0F
`define GCS_OFF_SCALED_ENERGY_LOW 7'h10
`define GCS_OFF_AVAIL_CHARGE_LOW 7'h17
`define GCS_OFF_SRST 7'h39

`define GCS_CMD_DIR 7
`define GCS_SRST_BIT 7
`define GCS_F_CHARGE_ACTIVE_FLAG 7
`define GCS_F_BRP 6
`define GCS_F_CI 4
`define GCS_F_VDQ 3
`define GCS_F_FIRST_EOD_FLAG 1
`define GCS_F_FINAL_EOD_FLAG 0

`define GCS_AVAIL_CHARGE_HIGH_RST 8'h00
`define GCS_PACKID_RST 8'h00
`define GCS_VTS_RST 8'h00
`define GCS_CPI_RST 8'h00
`define GCS_CPI_PRE_CI 8'h3F
`define GCS_CPI_MAX 8'hFF
`define GCS_FINAL_EOD_FLAG_DELTA_MV 50

`define GCS_T_START_US 200
`define GCS_T_SAMPLE_US 1000
`define GCS_T_STOP_US 2000
`define GCS_T_CYCLE_US 3000
`define GCS_T_BREAK_US 4000
`define GCS_T_BLINK_HALF_US 125000

`endif

// File: src/gcs_pkg.sv
package gcs_pkg;
  typedef logic [7:0] gcs_byte_t;
  typedef logic [6:0] gcs_addr_t;
  typedef enum logic [1:0] {GCS_ST_CMD, GCS_ST_WDATA, GCS_ST_RDATA} gcs_link_e;
endpackage

// File: src/gcs_dq_bit.sv
`timescale 1ns/10ps
`include "gcs_defines.svh"
module gcs_dq_bit #(
  parameter int CW = 20,
  parameter int START_CYC = `GCS_US_TO_CYC(`GCS_T_START_US),
  parameter int SAMPLE_CYC = `GCS_US_TO_CYC(`GCS_T_SAMPLE_US),
  parameter int STOP_CYC = `GCS_US_TO_CYC(`GCS_T_STOP_US),
  parameter int CYCLE_CYC = `GCS_US_TO_CYC(`GCS_T_CYCLE_US),
  parameter int BREAK_CYC = `GCS_US_TO_CYC(`GCS_T_BREAK_US)
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic dq_in,
  output logic dq_oe_n,
  input wire logic tx_start,
  input wire logic tx_bit,
  output logic tx_done,
  output logic rx_valid,
  output logic rx_bit,
  output logic brk
);
  logic s1_q, s2_q, s3_q;
  logic rx_run_q, tx_run_q, tx_val_q;
  logic [CW-1:0] rx_cnt_q, tx_cnt_q, low_cnt_q;

  // Pin crosses two flops before any use
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= dq_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Receive frame timer; own transmissions are not echoed back
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_run_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (tx_run_q || brk) begin
        rx_run_q <= 1'b0;
      end else if (!rx_run_q && s3_q && !s2_q) begin
        rx_run_q <= 1'b1;
        rx_cnt_q <= '0;
      end else if (rx_run_q) begin
        rx_cnt_q <= rx_cnt_q + 1'b1;
        if (rx_cnt_q == CW'(SAMPLE_CYC)) begin
          rx_valid <= 1'b1;
          rx_bit <= s2_q;
          rx_run_q <= 1'b0;
        end
      end
    end
  end

  // Long low time is a break; reported once per low period
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_q <= '0;
      brk <= 1'b0;
    end else begin
      brk <= 1'b0;
      if (s2_q) begin
        low_cnt_q <= '0;
      end else if (low_cnt_q != CW'(BREAK_CYC)) begin
        low_cnt_q <= low_cnt_q + 1'b1;
        brk <= (low_cnt_q == CW'(BREAK_CYC - 1)) && !tx_run_q;
      end
    end
  end

  // Return-to-one transmit: start low, data, release until cycle end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_run_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_val_q <= 1'b0;
      tx_done <= 1'b0;
      dq_oe_n <= 1'b1;
    end else begin
      tx_done <= 1'b0;
      if (tx_start && !tx_run_q) begin
        tx_run_q <= 1'b1;
        tx_cnt_q <= '0;
        tx_val_q <= tx_bit;
        dq_oe_n <= 1'b0;
      end else if (tx_run_q) begin
        tx_cnt_q <= tx_cnt_q + 1'b1;
        if (tx_cnt_q == CW'(START_CYC)) begin
          dq_oe_n <= tx_val_q;
        end
        if (tx_cnt_q == CW'(STOP_CYC)) begin
          dq_oe_n <= 1'b1;
        end
        if (tx_cnt_q == CW'(CYCLE_CYC)) begin
          tx_run_q <= 1'b0;
          tx_done <= 1'b1;
        end
      end
    end
  end
endmodule

// File: src/gcs_regs.sv
// Overview of operation
// - A command is decoded only after eight command bits have arrived.
// - Direction bit zero sends the addressed register's eight bits back.
// - Direction bit one stores the next eight received bits at the address.
// - Address is the low seven command bits, bit zero least significant.
// - Writes to addresses without a writable register change nothing.
// - Charge-active flag, bit 7, sets while sensed voltage exceeds qualification.
// - Charge-active clears below qualification or on any discharge activity.
// - Battery-replaced flag, bit 6, sets on power-up and serial reset.
// - Battery-replaced clears on valid charge reaching capacity or after first EOD.
// - Capacity-inaccurate flag, bit 4, sets on 64th charge and on reset.
// - Capacity-inaccurate clears when full capacity is updated by discharge.
// - Valid-discharge flag, bit 3, sets on discharge starting from full.
// - Valid-discharge clears when self-discharge count reaches its limit.
// - Valid-discharge clears after sustained charge of 256 counts.
// - Valid-discharge clears if first EOD sets below zero degrees.
// - With first EOD, display enabled and final EOD clear, segment one blinks at 4 Hz.
// - First EOD, bit 1, sets on low voltage under 2C, latched until charge.
// - First EOD threshold comes from the host-writable threshold register.
// - Final EOD, bit 0, sets 50 mV below first threshold under 2C.
// - While final EOD is set every segment driver is off.
// - Final EOD stays latched until a valid charge.
// - Bytes travel least significant bit first, at most 333 bits per second.
// - A break reinitialises the serial interface.
`timescale 1ns/10ps
`include "gcs_defines.svh"
module gcs_regs #(
  parameter int MV_PER_LSB = 1,
  parameter int BLINK_HALF_CYC = `GCS_US_TO_CYC(`GCS_T_BLINK_HALF_US),
  parameter int BIT_START_CYC = `GCS_US_TO_CYC(`GCS_T_START_US),
  parameter int BIT_SAMPLE_CYC = `GCS_US_TO_CYC(`GCS_T_SAMPLE_US),
  parameter int BIT_STOP_CYC = `GCS_US_TO_CYC(`GCS_T_STOP_US),
  parameter int BIT_CYCLE_CYC = `GCS_US_TO_CYC(`GCS_T_CYCLE_US),
  parameter int BIT_BREAK_CYC = `GCS_US_TO_CYC(`GCS_T_BREAK_US)
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe_n,
  input wire logic disp_enable,
  input wire logic [4:0] seg_pattern,
  output logic display_segment_one,
  output logic [3:0] display_segments_hi,
  input wire logic sensed_above_qual,
  input wire logic discharge_active,
  input wire logic valid_charge,
  input wire logic cpi_qualify,
  input wire logic nac_eq_lmd,
  input wire logic discharge_start,
  input wire logic lmd_update,
  input wire logic [7:0] lmd_new_value,
  input wire logic self_discharge_count_limit,
  input wire logic charge_256,
  input wire logic temp_below_zero,
  input wire logic rate_under_2c,
  input wire logic [7:0] prog_full_count,
  input wire logic [7:0] battery_voltage,
  input wire logic [7:0] temperature_gauge,
  input wire logic [7:0] secondary_flags,
  input wire logic [7:0] prog_pin_pulldown,
  input wire logic [7:0] prog_pin_pullup,
  input wire logic [7:0] comp_capacity_high,
  input wire logic [7:0] comp_capacity_low,
  input wire logic [7:0] scaled_energy_high,
  input wire logic [7:0] scaled_energy_low,
  input wire logic [7:0] avail_charge_low,
  output logic [7:0] primary_flags,
  output logic [7:0] avail_charge_high,
  output logic [7:0] pack_identifier,
  output logic [7:0] measured_full_capacity,
  output logic [7:0] eod_threshold,
  output logic [7:0] inaccuracy_count,
  output logic nac_written,
  output logic soft_reset_pulse
);
  localparam logic [7:0] FINAL_EOD_FLAG_DELTA = 8'(`GCS_FINAL_EOD_FLAG_DELTA_MV / MV_PER_LSB);

  gcs_pkg::gcs_link_e st_q;
  gcs_pkg::gcs_byte_t sh_q, rx_byte, rd_byte, tx_sh_q, wr_data_q;
  gcs_pkg::gcs_addr_t wr_addr_q;
  logic [2:0] cnt_q;
  logic tx_start_q, wr_go_q, lmd_load_q;
  logic tx_done, rx_valid, rx_bit, brk;
  logic charge_active_flag_q, brp_q, ci_q, vdq_q, first_eod_flag_q, final_eod_flag_q;
  logic disp_s1_q, disp_s2_q, blink_q;
  logic [23:0] blink_cnt_q;
  logic first_eod_flag_set, final_eod_flag_set, cpi_inc, ci_hit;
  logic [7:0] final_eod_flag_thr;

  function automatic logic wr_ok(input gcs_pkg::gcs_addr_t a);
    wr_ok = (a == `GCS_OFF_AVAIL_CHARGE_HIGH) || (a == `GCS_OFF_PACKID) || (a == `GCS_OFF_LMD) ||
            (a == `GCS_OFF_VTS) || (a == `GCS_OFF_SRST);
  endfunction

  assign dq_out = 1'b0;

  gcs_dq_bit #(
    .START_CYC(BIT_START_CYC),
    .SAMPLE_CYC(BIT_SAMPLE_CYC),
    .STOP_CYC(BIT_STOP_CYC),
    .CYCLE_CYC(BIT_CYCLE_CYC),
    .BREAK_CYC(BIT_BREAK_CYC)
  ) u_bit (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .dq_in(dq_in),
    .dq_oe_n(dq_oe_n),
    .tx_start(tx_start_q),
    .tx_bit(tx_sh_q[0]),
    .tx_done(tx_done),
    .rx_valid(rx_valid),
    .rx_bit(rx_bit),
    .brk(brk)
  );

  assign rx_byte = {rx_bit, sh_q[7:1]};

  // unused bits of the flag byte stay zero
  assign primary_flags = {charge_active_flag_q, brp_q, 1'b0, ci_q, vdq_q, 1'b0, first_eod_flag_q, final_eod_flag_q};

  // low seven bits select the register
  always_comb begin
    rd_byte = 8'h00;
    unique case (rx_byte[6:0])
      `GCS_OFF_FLAGS1: rd_byte = primary_flags;
      `GCS_OFF_TEMP: rd_byte = temperature_gauge;
      `GCS_OFF_AVAIL_CHARGE_HIGH: rd_byte = avail_charge_high;
      `GCS_OFF_PACKID: rd_byte = pack_identifier;
      `GCS_OFF_LMD: rd_byte = measured_full_capacity;
      `GCS_OFF_FLAGS2: rd_byte = {1'b0, secondary_flags[6:4], 3'b000, secondary_flags[0]};
      `GCS_OFF_PPD: rd_byte = {2'b00, prog_pin_pulldown[5:0]};
      `GCS_OFF_PPU: rd_byte = {2'b00, prog_pin_pullup[5:0]};
      `GCS_OFF_CPI: rd_byte = inaccuracy_count;
      `GCS_OFF_VBAT: rd_byte = battery_voltage;
      `GCS_OFF_VTS: rd_byte = eod_threshold;
      `GCS_OFF_COMP_CAPACITY_HIGH: rd_byte = comp_capacity_high;
      `GCS_OFF_COMP_CAPACITY_LOW: rd_byte = comp_capacity_low;
      `GCS_OFF_SCALED_ENERGY_HIGH: rd_byte = scaled_energy_high;
      `GCS_OFF_SCALED_ENERGY_LOW: rd_byte = scaled_energy_low;
      `GCS_OFF_AVAIL_CHARGE_LOW: rd_byte = avail_charge_low;
      default: rd_byte = 8'h00;
    endcase
  end

  // Link sequencing; a break drops any half-done byte
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= gcs_pkg::GCS_ST_CMD;
      sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      cnt_q <= 3'd0;
      tx_start_q <= 1'b0;
      wr_go_q <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
    end else begin
      tx_start_q <= 1'b0;
      wr_go_q <= 1'b0;
      if (brk || soft_reset_pulse) begin
        st_q <= gcs_pkg::GCS_ST_CMD;
        cnt_q <= 3'd0;
      end else begin
        unique case (st_q)
          gcs_pkg::GCS_ST_CMD: begin
            if (rx_valid) begin
              sh_q <= rx_byte;
              cnt_q <= cnt_q + 3'd1;
              if (cnt_q == 3'd7) begin
                wr_addr_q <= rx_byte[6:0];
                if (rx_byte[`GCS_CMD_DIR]) begin
                  st_q <= gcs_pkg::GCS_ST_WDATA;
                end else begin
                  st_q <= gcs_pkg::GCS_ST_RDATA;
                  tx_sh_q <= rd_byte;
                  tx_start_q <= 1'b1;
                end
              end
            end
          end
          gcs_pkg::GCS_ST_WDATA: begin
            if (rx_valid) begin
              sh_q <= rx_byte;
              cnt_q <= cnt_q + 3'd1;
              if (cnt_q == 3'd7) begin
                wr_data_q <= rx_byte;
                wr_go_q <= 1'b1;
                st_q <= gcs_pkg::GCS_ST_CMD;
              end
            end
          end
          gcs_pkg::GCS_ST_RDATA: begin
            if (tx_done) begin
              cnt_q <= cnt_q + 3'd1;
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              if (cnt_q == 3'd7) begin
                st_q <= gcs_pkg::GCS_ST_CMD;
              end else begin
                tx_start_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // Serial reset command
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= wr_go_q && (wr_addr_q == `GCS_OFF_SRST) && wr_data_q[`GCS_SRST_BIT];
    end
  end

  // Strap-like full count is loaded by a clocked step after either reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lmd_load_q <= 1'b1;
    end else begin
      lmd_load_q <= soft_reset_pulse;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      avail_charge_high <= `GCS_AVAIL_CHARGE_HIGH_RST;
      pack_identifier <= `GCS_PACKID_RST;
      measured_full_capacity <= 8'h00;
      eod_threshold <= `GCS_VTS_RST;
      nac_written <= 1'b0;
    end else begin
      nac_written <= 1'b0;
      if (soft_reset_pulse) begin
        avail_charge_high <= `GCS_AVAIL_CHARGE_HIGH_RST;
      end else if (lmd_load_q) begin
        measured_full_capacity <= prog_full_count;
      end else if (wr_go_q && wr_ok(wr_addr_q)) begin
        // read-only offsets never reach this decode
        unique case (wr_addr_q)
          `GCS_OFF_AVAIL_CHARGE_HIGH: begin
            avail_charge_high <= wr_data_q;
            nac_written <= 1'b1;
          end
          `GCS_OFF_PACKID: pack_identifier <= wr_data_q;
          `GCS_OFF_LMD: measured_full_capacity <= wr_data_q;
          `GCS_OFF_VTS: eod_threshold <= wr_data_q;
          default: ;
        endcase
      end else if (lmd_update) begin
        measured_full_capacity <= lmd_new_value;
      end
    end
  end

  // Charge count saturates rather than wrapping
  assign cpi_inc = valid_charge && cpi_qualify && (inaccuracy_count != `GCS_CPI_MAX);
  assign ci_hit = cpi_inc && (inaccuracy_count == `GCS_CPI_PRE_CI);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      inaccuracy_count <= `GCS_CPI_RST;
    end else if (soft_reset_pulse || lmd_update) begin
      inaccuracy_count <= `GCS_CPI_RST;
    end else if (cpi_inc) begin
      inaccuracy_count <= inaccuracy_count + 8'h01;
    end
  end

  assign first_eod_flag_set = (battery_voltage < eod_threshold) && rate_under_2c;
  // final threshold sits below the first, floored at zero
  assign final_eod_flag_thr = (eod_threshold > FINAL_EOD_FLAG_DELTA) ? (eod_threshold - FINAL_EOD_FLAG_DELTA) : 8'h00;
  assign final_eod_flag_set = (battery_voltage < final_eod_flag_thr) && rate_under_2c;

  // Set terms win over clears in every flag below except charge-active, where discharge activity wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      charge_active_flag_q <= 1'b0;
      brp_q <= 1'b1;
      ci_q <= 1'b1;
      vdq_q <= 1'b0;
      first_eod_flag_q <= 1'b0;
      final_eod_flag_q <= 1'b0;
    end else if (soft_reset_pulse) begin
      charge_active_flag_q <= 1'b0;
      brp_q <= 1'b1;
      ci_q <= 1'b1;
      vdq_q <= 1'b0;
      first_eod_flag_q <= 1'b0;
      final_eod_flag_q <= 1'b0;
    end else begin
      charge_active_flag_q <= sensed_above_qual && !discharge_active;
      // cleared by charge reaching full or after first EOD
      if (valid_charge && (nac_eq_lmd || first_eod_flag_q)) begin
        brp_q <= 1'b0;
      end
      if (ci_hit) begin
        ci_q <= 1'b1;
      end else if (lmd_update) begin
        ci_q <= 1'b0;
      end
      if (discharge_start && nac_eq_lmd) begin
        vdq_q <= 1'b1;
      end else if (lmd_update || self_discharge_count_limit || charge_256 ||
                   (first_eod_flag_set && !first_eod_flag_q && temp_below_zero)) begin
        vdq_q <= 1'b0;
      end
      if (first_eod_flag_set) begin
        first_eod_flag_q <= 1'b1;
      end else if (valid_charge) begin
        first_eod_flag_q <= 1'b0;
      end
      if (final_eod_flag_set) begin
        final_eod_flag_q <= 1'b1;
      end else if (valid_charge) begin
        final_eod_flag_q <= 1'b0;
      end
    end
  end

  // Display control is a pin and crosses two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      disp_s1_q <= 1'b0;
      disp_s2_q <= 1'b0;
    end else begin
      disp_s1_q <= disp_enable;
      disp_s2_q <= disp_s1_q;
    end
  end

  // 4 Hz square wave, free running
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_q <= 24'h000000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == 24'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_q <= 24'h000000;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 24'h000001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      display_segment_one <= 1'b0;
      display_segments_hi <= 4'h0;
    end else if (final_eod_flag_q || !disp_s2_q) begin
      display_segment_one <= 1'b0;
      display_segments_hi <= 4'h0;
    end else begin
      // segment one modulated once first EOD is set
      display_segment_one <= first_eod_flag_q ? blink_q : seg_pattern[0];
      display_segments_hi <= seg_pattern[4:1];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence cmd_read_done;
    (st_q == gcs_pkg::GCS_ST_CMD) && rx_valid && (cnt_q == 3'd7) && !rx_bit && !brk;
  endsequence
  sequence cmd_write_done;
    (st_q == gcs_pkg::GCS_ST_WDATA) && rx_valid && (cnt_q == 3'd7) && !brk && !soft_reset_pulse;
  endsequence

  a_read_answer: assert property (cmd_read_done |=> tx_start_q ##1 !tx_start_q)
    else $error("read command did not start the answer");
  a_write_store: assert property (cmd_write_done |=> wr_go_q ##1 (st_q == gcs_pkg::GCS_ST_CMD))
    else $error("write data not committed");
  a_invalid_write: assert property (wr_go_q && !wr_ok(wr_addr_q) && !lmd_load_q && !lmd_update
      |=> $stable(avail_charge_high) && $stable(eod_threshold) && $stable(pack_identifier)
          && $stable(measured_full_capacity))
    else $error("invalid write changed a register");
  a_charge_active_flag_discharge: assert property (discharge_active && !soft_reset_pulse |=> !primary_flags[7])
    else $error("charge flag set during discharge");
  a_brp_reset: assert property (soft_reset_pulse |=> brp_q && ci_q && !final_eod_flag_q)
    else $error("serial reset did not mark replacement");
  a_ci_clear: assert property (lmd_update && !ci_hit && !soft_reset_pulse
      |=> !ci_q && (inaccuracy_count == `GCS_CPI_RST))
    else $error("capacity flag not cleared on update");
  a_ci_hit: assert property (ci_hit && !lmd_update && !soft_reset_pulse
      |=> ci_q && (inaccuracy_count == 8'h40))
    else $error("64th charge did not set capacity flag");
  a_vdq_self_discharge_count: assert property (self_discharge_count_limit && !(discharge_start && nac_eq_lmd) && !soft_reset_pulse
      |=> !vdq_q)
    else $error("valid discharge kept past self-discharge limit");
  a_first_eod_flag_latch: assert property (first_eod_flag_q && !valid_charge && !soft_reset_pulse |=> first_eod_flag_q)
    else $error("first EOD dropped without charge");
  a_final_eod_flag_blank: assert property (final_eod_flag_q |=> !display_segment_one && (display_segments_hi == 4'h0))
    else $error("segments driven during final EOD");
  a_break_reinit: assert property (brk |=> (st_q == gcs_pkg::GCS_ST_CMD) && (cnt_q == 3'd0))
    else $error("break did not reinitialise the link");
endmodule

// File: bench/gcs_host.sv
`timescale 1ns/10ps
module gcs_host #(
  parameter int START_CYC = 20000,
  parameter int SAMPLE_CYC = 100000,
  parameter int STOP_CYC = 200000,
  parameter int CYCLE_CYC = 300000,
  parameter int BREAK_CYC = 400000
) (
  input wire logic ref_clk,
  input wire logic dq_wire,
  output logic host_low
);
  initial begin
    host_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic send_bit(input logic b);
    host_low = 1'b1;
    wt(START_CYC);
    host_low = ~b;
    wt(STOP_CYC - START_CYC);
    host_low = 1'b0;
    wt(CYCLE_CYC - STOP_CYC);
  endtask
  task automatic send_break;
    host_low = 1'b1;
    wt(BREAK_CYC + 10);
    host_low = 1'b0;
    wt(CYCLE_CYC);
  endtask
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] w;
    w = {data, 1'b1, addr};
    for (int i = 0; i < 16; i++) begin
      send_bit(w[i]);
    end
  endtask
  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    for (int i = 0; i < 7; i++) begin
      send_bit(addr[i]);
    end
    // Hold low past the device start, so its first fall is hidden
    host_low = 1'b1;
    wt(SAMPLE_CYC + 10);
    host_low = 1'b0;
    wt(SAMPLE_CYC - 4);
    data[0] = dq_wire;
    for (int i = 1; i < 8; i++) begin
      while (!dq_wire) wt(1);
      while (dq_wire) wt(1);
      wt(SAMPLE_CYC);
      data[i] = dq_wire;
    end
    while (!dq_wire) wt(1);
    // Let the device finish its last frame before the next command when its last bit is zero
    wt(CYCLE_CYC - STOP_CYC + 4);
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
`include "gcs_defines.svh"
module tb_top;
  localparam int VC = 0;
  localparam int DS = 1;
  localparam int LU = 2;
  localparam int SD = 3;
  localparam int C256 = 4;
  logic ref_clk, rstn, host_low, dq_out, dq_oe_n, dq_wire;
  logic disp_enable, sensed_above_qual, discharge_active, valid_charge, cpi_qualify;
  logic nac_eq_lmd, discharge_start, lmd_update, self_discharge_count_limit, charge_256;
  logic temp_below_zero, rate_under_2c, display_segment_one, nac_written, soft_reset_pulse;
  logic [4:0] seg_pattern;
  logic [3:0] display_segments_hi;
  logic [7:0] lmd_new_value, prog_full_count, battery_voltage, ro_data, rd, cnt;
  logic [7:0] primary_flags, avail_charge_high, pack_identifier, measured_full_capacity;
  logic [7:0] eod_threshold, inaccuracy_count;
  int n_mismatch, n_compared;
  logic [7:0] n_nacw = 8'h00;
  logic [7:0] n_srst = 8'h00;
  // Open drain wire with pull-up
  assign dq_wire = ~(host_low | ~dq_oe_n);
  gcs_regs #(.MV_PER_LSB(1), .BLINK_HALF_CYC(8), .BIT_START_CYC(2), .BIT_SAMPLE_CYC(10),
    .BIT_STOP_CYC(20), .BIT_CYCLE_CYC(30), .BIT_BREAK_CYC(40)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .dq_in(dq_wire), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .disp_enable(disp_enable), .seg_pattern(seg_pattern),
    .display_segment_one(display_segment_one), .display_segments_hi(display_segments_hi),
    .sensed_above_qual(sensed_above_qual), .discharge_active(discharge_active),
    .valid_charge(valid_charge), .cpi_qualify(cpi_qualify), .nac_eq_lmd(nac_eq_lmd),
    .discharge_start(discharge_start), .lmd_update(lmd_update), .lmd_new_value(lmd_new_value),
    .self_discharge_count_limit(self_discharge_count_limit), .charge_256(charge_256), .temp_below_zero(temp_below_zero),
    .rate_under_2c(rate_under_2c), .prog_full_count(prog_full_count),
    .battery_voltage(battery_voltage), .temperature_gauge(ro_data), .secondary_flags(ro_data),
    .prog_pin_pulldown(ro_data), .prog_pin_pullup(ro_data), .comp_capacity_high(ro_data),
    .comp_capacity_low(ro_data), .scaled_energy_high(ro_data), .scaled_energy_low(ro_data),
    .avail_charge_low(ro_data), .primary_flags(primary_flags),
    .avail_charge_high(avail_charge_high), .pack_identifier(pack_identifier),
    .measured_full_capacity(measured_full_capacity), .eod_threshold(eod_threshold),
    .inaccuracy_count(inaccuracy_count), .nac_written(nac_written),
    .soft_reset_pulse(soft_reset_pulse)
  );
  // Short bit timing at both ends keeps the run brief
  gcs_host #(.START_CYC(2), .SAMPLE_CYC(10), .STOP_CYC(20), .CYCLE_CYC(30),
    .BREAK_CYC(40)) host (.ref_clk(ref_clk), .dq_wire(dq_wire), .host_low(host_low));
  // Pulse outputs counted so one-cycle strobes are not missed
  always @(posedge ref_clk) begin
    if (nac_written === 1'b1) n_nacw <= n_nacw + 8'h01;
    if (soft_reset_pulse === 1'b1) n_srst <= n_srst + 8'h01;
  end
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(input int k);
    {charge_256, self_discharge_count_limit, lmd_update, discharge_start, valid_charge} = 5'h01 << k;
    step(1);
    {charge_256, self_discharge_count_limit, lmd_update, discharge_start, valid_charge} = 5'h00;
    step(2);
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_charge_active_flag;
    check(primary_flags, 8'h50);
    check(inaccuracy_count, 8'h00);
    sensed_above_qual = 1'b1;
    step(3);
    check(primary_flags, 8'hD0);
    discharge_active = 1'b1;
    step(3);
    check(primary_flags, 8'h50);
    discharge_active = 1'b0;
    step(3);
    sensed_above_qual = 1'b0;
    step(3);
    check(primary_flags, 8'h50);
  endtask
  task automatic t_vdq;
    nac_eq_lmd = 1'b1;
    pulse(DS);
    check(primary_flags, 8'h58);
    pulse(SD);
    check(primary_flags, 8'h50);
    pulse(DS);
    pulse(C256);
    check(primary_flags, 8'h50);
    pulse(DS);
    lmd_new_value = 8'h3C;
    pulse(LU);
    check(primary_flags, 8'h40);
    check(measured_full_capacity, 8'h3C);
    nac_eq_lmd = 1'b0;
    pulse(DS);
    check(primary_flags, 8'h40);
  endtask
  task automatic t_cpi;
    cpi_qualify = 1'b1;
    repeat (63) pulse(VC);
    check(inaccuracy_count, 8'h3F);
    check(primary_flags, 8'h40);
    pulse(VC);
    check(inaccuracy_count, 8'h40);
    check(primary_flags, 8'h50);
  endtask
  task automatic t_eod;
    host.write_reg(`GCS_OFF_VTS, 8'h80);
    step(4);
    check(eod_threshold, 8'h80);
    nac_eq_lmd = 1'b1;
    pulse(DS);
    nac_eq_lmd = 1'b0;
    temp_below_zero = 1'b1;
    battery_voltage = 8'h80;
    step(3);
    check(primary_flags, 8'h58);
    battery_voltage = 8'h7F;
    step(3);
    check(primary_flags, 8'h52);
    disp_enable = 1'b1;
    step(4);
    cnt = 8'h00;
    rd = {7'h00, display_segment_one};
    repeat (24) begin
      step(1);
      if (display_segment_one !== rd[0]) cnt++;
      rd = {7'h00, display_segment_one};
    end
    check(cnt, 8'h03);
    check({4'h0, display_segments_hi}, 8'h0F);
    battery_voltage = 8'h4E;
    step(3);
    check(primary_flags, 8'h52);
    battery_voltage = 8'h4D;
    step(4);
    check(primary_flags, 8'h53);
    check({3'h0, display_segment_one, display_segments_hi}, 8'h00);
    battery_voltage = 8'hFF;
    step(3);
    check(primary_flags, 8'h53);
    pulse(VC);
    check(primary_flags, 8'h10);
  endtask
  task automatic t_read;
    host.read_reg(`GCS_OFF_FLAGS1, rd);
    check(rd, 8'h10);
    host.read_reg(`GCS_OFF_PPD, rd);
    check(rd, 8'h1A);
    host.read_reg(`GCS_OFF_TEMP, rd);
    check(rd, 8'h5A);
  endtask
  task automatic t_srst;
    host.write_reg(`GCS_OFF_TEMP, 8'h77);
    step(4);
    check(avail_charge_high, 8'h00);
    check(measured_full_capacity, 8'h3C);
    repeat (3) host.send_bit(1'b1);
    host.send_break();
    host.write_reg(`GCS_OFF_AVAIL_CHARGE_HIGH, 8'h21);
    step(4);
    check(avail_charge_high, 8'h21);
    check(n_nacw, 8'h01);
    host.write_reg(`GCS_OFF_SRST, 8'h80);
    step(4);
    check(n_srst, 8'h01);
    check(primary_flags, 8'h50);
    check(avail_charge_high, 8'h00);
    check(measured_full_capacity, 8'hA5);
    check(inaccuracy_count, 8'h00);
    check(eod_threshold, 8'h80);
  endtask
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    rstn = 1'b0;
    {disp_enable, sensed_above_qual, discharge_active, cpi_qualify, nac_eq_lmd} = 5'h00;
    {charge_256, self_discharge_count_limit, lmd_update, discharge_start, valid_charge} = 5'h00;
    temp_below_zero = 1'b0;
    rate_under_2c = 1'b1;
    seg_pattern = 5'h1F;
    lmd_new_value = 8'h00;
    prog_full_count = 8'hA5;
    battery_voltage = 8'hFF;
    ro_data = 8'h5A;
    repeat (3) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    step(3);
    t_charge_active_flag();
    t_vdq();
    t_cpi();
    t_eod();
    t_read();
    t_srst();
    results();
  end
endmodule
